// ---- spt_pkg.sv ----
// Constants for the SCSI protocol timers
package spt_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_INT_ENABLE_ONE  = 8'h41;
  localparam logic [7:0] ADDR_INT_STATUS_ONE  = 8'h43;
  localparam logic [7:0] ADDR_TIMER_CFG_ZERO  = 8'h48;
  localparam logic [7:0] ADDR_TIMER_CFG_ONE   = 8'h49;
  localparam logic [7:0] ADDR_PURPOSE_CTRL    = 8'h60;
  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int HSK_GAP_LSB         = 4;
  localparam int CHOOSE_LSB          = 0;
  localparam int PURPOSE_PERIOD_LSB  = 0;
  localparam int HSK_GAP_SCALE_BIT   = 4;
  localparam int PURPOSE_SCALE_BIT   = 5;
  localparam int BUS_WATCH_BIT       = 6;
  localparam int FLAG_HSK_BIT        = 0;
  localparam int FLAG_PURPOSE_BIT    = 1;
  localparam int FLAG_CHOOSE_BIT     = 2;
  localparam int PURPOSE_RUN_BIT     = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_TIMER_CFG_ZERO   = 8'h00;
  localparam logic [6:0] RST_TIMER_CFG_ONE    = 7'h00;
  localparam logic [2:0] RST_INT_ENABLE_ONE   = 3'h0;
  localparam logic [2:0] RST_INT_STATUS_ONE   = 3'h0;
  localparam logic       RST_PURPOSE_RUN      = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ      = 100;
  localparam int BASE_TICK_US = 100;
  localparam int ABORT_US     = 200;
  localparam int BASE_CYCLES  = BASE_TICK_US * CLK_MHZ;
  localparam int ABORT_TICKS  = (ABORT_US + BASE_TICK_US - 1) / BASE_TICK_US;
  localparam int SCALE_SHIFT  = 4;
  localparam int TICK_CNT_W   = 19;
endpackage : spt_pkg

// ---- spt_timer.sv ----
// One programmable timeout counter driven by the shared base tick
`timescale 1ns/1ps
`default_nettype none
module spt_timer #(
  parameter int CNT_W = 19,
  parameter int EXTRA = 0
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_tick,
  input  wire logic       i_run,
  input  wire logic       i_restart,
  input  wire logic [3:0] i_code,
  input  wire logic       i_scale,
  output logic            o_expire
);
  logic [CNT_W-1:0] cnt_q;
  logic             done_q;
  logic [CNT_W-1:0] limit;
  logic             idle;

  ////////////////////////////////////////////////////////////////////////////
  // Period from code: base times two to the code minus one, optional x16
  always_comb begin
    limit = CNT_W'(1) << (i_code - 4'h1);
    if (i_scale) begin
      limit = limit << spt_pkg::SCALE_SHIFT;
    end
    limit = limit + CNT_W'(EXTRA);
  end

  assign idle = !i_run || (i_code == 4'h0) || i_restart;

  ////////////////////////////////////////////////////////////////////////////
  // Count base ticks, fire once
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q    <= '0;
      done_q   <= 1'b0;
      o_expire <= 1'b0;
    end else begin
      o_expire <= 1'b0;
      if (idle) begin
        cnt_q  <= '0;
        done_q <= 1'b0;
      end else if (i_tick && !done_q) begin
        if (cnt_q + CNT_W'(1) >= limit) begin
          done_q   <= 1'b1;
          o_expire <= 1'b1;
        end
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end
endmodule : spt_timer
`default_nettype wire

// ---- spt_top.sv ----
// SCSI protocol timers: handshake gap, selection and general purpose
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module spt_top
  import spt_pkg::*;
#(
  parameter int BASE_CYCLES_P = spt_pkg::BASE_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_req_n,
  input  wire logic       i_ack_n,
  input  wire logic       i_bsy_n,
  input  wire logic       i_target_mode,
  input  wire logic       i_connected,
  input  wire logic       i_choose_active,
  output logic      [7:0] o_rdata,
  output logic            o_irq
);
  import spt_pkg::*;

  localparam int PRE_W = $clog2(BASE_CYCLES_P + 1);

  logic [7:0] timer_config_zero_q;
  logic [6:0] timer_config_one_q;
  logic [2:0] interrupt_enable_one_q;
  logic [2:0] interrupt_status_one_q;
  logic       purpose_run_q;
  logic [PRE_W-1:0] pre_q;
  logic       tick_q;
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;
  logic [2:0] pin_q;
  logic [2:0] pin_prev_q;
  logic       req_edge;
  logic       ack_edge;
  logic       bsy_on;
  logic       hsk_edge;
  logic       hsk_run;
  logic       hsk_exp;
  logic       choose_exp;
  logic       purpose_exp;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      timer_config_zero_q    <= RST_TIMER_CFG_ZERO;
      timer_config_one_q     <= RST_TIMER_CFG_ONE;
      interrupt_enable_one_q <= RST_INT_ENABLE_ONE;
      purpose_run_q          <= RST_PURPOSE_RUN;
    end else if (i_wr) begin
      case (i_addr)
        ADDR_TIMER_CFG_ZERO: timer_config_zero_q    <= i_wdata;
        ADDR_TIMER_CFG_ONE:  timer_config_one_q     <= i_wdata[6:0];
        ADDR_INT_ENABLE_ONE: interrupt_enable_one_q <= i_wdata[2:0];
        ADDR_PURPOSE_CTRL:   purpose_run_q          <= i_wdata[PURPOSE_RUN_BIT];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_TIMER_CFG_ZERO: o_rdata <= timer_config_zero_q;
        ADDR_TIMER_CFG_ONE:  o_rdata <= {1'b0, timer_config_one_q};
        ADDR_INT_ENABLE_ONE: o_rdata <= {5'h00, interrupt_enable_one_q};
        ADDR_INT_STATUS_ONE: o_rdata <= {5'h00, interrupt_status_one_q};
        ADDR_PURPOSE_CTRL:   o_rdata <= {7'h00, purpose_run_q};
        default:             o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers with agreement filter
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_q   <= 3'h7;
      pin_s2_q   <= 3'h7;
      pin_s3_q   <= 3'h7;
      pin_q      <= 3'h7;
      pin_prev_q <= 3'h7;
    end else begin
      pin_s1_q   <= {i_bsy_n, i_ack_n, i_req_n};
      pin_s2_q   <= pin_s1_q;
      pin_s3_q   <= pin_s2_q;
      pin_prev_q <= pin_q;
      for (int i = 0; i < 3; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  assign req_edge = pin_prev_q[0] && !pin_q[0];
  assign ack_edge = pin_prev_q[1] && !pin_q[1];
  assign bsy_on   = !pin_q[2];
  assign hsk_run  = i_connected || (timer_config_one_q[BUS_WATCH_BIT] && bsy_on);

  ////////////////////////////////////////////////////////////////////////////
  // Qualifying handshake per role, or any REQ/ACK once bus watching is on
  always_comb begin
    if (timer_config_one_q[BUS_WATCH_BIT]) begin
      hsk_edge = req_edge || ack_edge;
    end else if (i_target_mode) begin
      hsk_edge = req_edge;
    end else begin
      hsk_edge = ack_edge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Base tick prescaler, one pulse per 100 us
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      if (pre_q == PRE_W'(BASE_CYCLES_P - 1)) begin
        pre_q  <= '0;
        tick_q <= 1'b1;
      end else begin
        pre_q  <= pre_q + PRE_W'(1);
        tick_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The three timers share one code-to-period mapping, the selection timer adding ABORT_TICKS
  spt_timer #(.CNT_W(TICK_CNT_W), .EXTRA(0)) u_hsk_timer (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_tick    (tick_q),
    .i_run     (hsk_run),
    .i_restart (hsk_edge),
    .i_code    (timer_config_zero_q[HSK_GAP_LSB +: 4]),
    .i_scale   (timer_config_one_q[HSK_GAP_SCALE_BIT]),
    .o_expire  (hsk_exp)
  );

  spt_timer #(.CNT_W(TICK_CNT_W), .EXTRA(ABORT_TICKS)) u_choose_timer (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_tick    (tick_q),
    .i_run     (i_choose_active),
    .i_restart (1'b0),
    .i_code    (timer_config_zero_q[CHOOSE_LSB +: 4]),
    .i_scale   (1'b0),
    .o_expire  (choose_exp)
  );

  spt_timer #(.CNT_W(TICK_CNT_W), .EXTRA(0)) u_purpose_timer (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_tick    (tick_q),
    .i_run     (purpose_run_q),
    .i_restart (1'b0),
    .i_code    (timer_config_one_q[PURPOSE_PERIOD_LSB +: 4]),
    .i_scale   (timer_config_one_q[PURPOSE_SCALE_BIT]),
    .o_expire  (purpose_exp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, cleared by read, set wins
  always_comb begin
    flag_set                   = 3'h0;
    flag_set[FLAG_HSK_BIT]     = hsk_exp;
    flag_set[FLAG_PURPOSE_BIT] = purpose_exp;
    flag_set[FLAG_CHOOSE_BIT]  = choose_exp;
    flag_clr = (i_rd && (i_addr == ADDR_INT_STATUS_ONE)) ? 3'h7 : 3'h0;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      interrupt_status_one_q <= RST_INT_STATUS_ONE;
    end else begin
      interrupt_status_one_q <= (interrupt_status_one_q & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(interrupt_status_one_q & interrupt_enable_one_q);
    end
  end
endmodule : spt_top
`default_nettype wire

// ---- spt_monitor.sv ----
// Concurrent checks on the timer block ports
`timescale 1ns/1ps
`default_nettype none
module spt_monitor
  import spt_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_irq
);
  logic [7:0] c0_q;
  logic [7:0] c1_q;
  logic [2:0] en_q;
  logic [2:0] off_q;
  logic       run_q;
  wire        rs = i_rd && i_addr == ADDR_INT_STATUS_ONE;
  wire        we = i_wr && i_addr == ADDR_INT_ENABLE_ONE;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the writable registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {c0_q, c1_q, en_q, run_q} <= 20'h00000;
    end else if (i_wr) begin
      case (i_addr)
        ADDR_TIMER_CFG_ZERO: c0_q <= i_wdata;
        ADDR_TIMER_CFG_ONE:  c1_q <= i_wdata & 8'h7F;
        ADDR_INT_ENABLE_ONE: en_q <= i_wdata[2:0];
        ADDR_PURPOSE_CTRL:   run_q <= i_wdata[0];
        default: ;
      endcase
    end
  end
  // Cycles the general timer has been stopped
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      off_q <= 3'h0;
    end else if (run_q && c1_q[3:0] != 4'h0) begin
      off_q <= 3'h0;
    end else if (off_q != 3'h7) begin
      off_q <= off_q + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_IRQ_MASKED: assert property (en_q == 3'h0 && $past(en_q) == 3'h0 |-> !o_irq)
    else $error("irq while masked");
  AST_IRQ_FROM_STATUS: assert property ($past(rs) |-> o_irq == |(o_rdata[2:0] & $past(en_q)))
    else $error("irq disagrees with status");
  AST_IRQ_STICKY: assert property ($past(o_irq) && !$past(rs, 2) && !$past(we, 2) |-> o_irq)
    else $error("irq dropped without read");
  AST_GEN_STOPPED: assert property (!o_irq && off_q == 3'h7 && en_q == 3'h2 && $past(en_q) == 3'h2 |=> !o_irq)
    else $error("stopped timer fired");
  AST_STATUS_PAD: assert property ($past(rs) |-> o_rdata[7:3] == 5'h00)
    else $error("status pad bits set");
  AST_CFG0_BACK: assert property ($past(i_rd && i_addr == ADDR_TIMER_CFG_ZERO) |-> o_rdata == $past(c0_q))
    else $error("config zero readback");
  AST_CFG1_BACK: assert property ($past(i_rd && i_addr == ADDR_TIMER_CFG_ONE) |-> o_rdata == $past(c1_q))
    else $error("config one readback");
  AST_EN_BACK: assert property ($past(i_rd && i_addr == ADDR_INT_ENABLE_ONE) |-> o_rdata == {5'h00, $past(en_q)})
    else $error("enable readback");
  cover property ($past(rs) && o_rdata[0]);
  cover property ($past(rs) && o_rdata[1]);
  cover property ($past(rs) && o_rdata[2]);
endmodule : spt_monitor
bind spt_top spt_monitor u_mon (
  .i_clk  (i_clk),
  .i_rst_n(i_rst_n),
  .i_addr (i_addr),
  .i_wdata(i_wdata),
  .i_wr   (i_wr),
  .i_rd   (i_rd),
  .o_rdata(o_rdata),
  .o_irq  (o_irq)
);
`default_nettype wire

// ---- spt_scsi_bus.sv ----
// Far-side SCSI agent pulsing REQ or ACK
`timescale 1ns/1ps
`default_nettype none
module spt_scsi_bus (
  input  wire logic i_clk,
  input  wire logic i_req_run,
  input  wire logic i_ack_run,
  input  wire logic i_bsy,
  output logic      o_req_n,
  output logic      o_ack_n,
  output logic      o_bsy_n
);
  logic [2:0] ph_q = 3'h0;
  // One handshake every six clocks; released lines are driven high
  always @(posedge i_clk) ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
  assign o_req_n = !(i_req_run && ph_q < 3'h2);
  assign o_ack_n = !(i_ack_run && ph_q < 3'h2);
  assign o_bsy_n = !i_bsy;
endmodule : spt_scsi_bus
`default_nettype wire

// ---- spt_top_tb.sv ----
// Self-checking bench for the protocol timers
`timescale 1ns/1ps
`default_nettype none
module spt_top_tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       tmode = 1'b1;
  logic       conn = 1'b0;
  logic       sel = 1'b0;
  logic       req_run = 1'b0;
  logic       ack_run = 1'b0;
  logic       bsy = 1'b0;
  logic       req_n;
  logic       ack_n;
  logic       bsy_n;
  logic [7:0] rdata;
  logic       irq;
  int         n_fail = 0;
  int         checked = 0;
  always #5 clk = ~clk;
  spt_top #(.BASE_CYCLES_P(4)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .i_req_n(req_n), .i_ack_n(ack_n), .i_bsy_n(bsy_n), .i_target_mode(tmode),
    .i_connected(conn), .i_choose_active(sel), .o_rdata(rdata), .o_irq(irq));
  spt_scsi_bus bus (.i_clk(clk), .i_req_run(req_run), .i_ack_run(ack_run), .i_bsy(bsy),
    .o_req_n(req_n), .o_ack_n(ack_n), .o_bsy_n(bsy_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rdc
  // Expiry lands between 4L-2 and 4L+5+X clocks after arming
  task automatic tmo(input logic [7:0] f, input int l, input int x, input logic ie);
    cyc(4 * l - 4);
    rdc(8'h43, 8'h00);
    cyc(8 + x);
    #1 chk({7'h00, irq}, {7'h00, ie});
    rdc(8'h43, f);
    cyc(1);
    #1 chk({7'h00, irq}, 8'h00);
  endtask : tmo
  task automatic end_of_test();
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(6);
    rst_n <= 1'b1;
    rdc(8'h48, 8'h00);
    rdc(8'h49, 8'h00);
    rdc(8'h41, 8'h00);
    rdc(8'h50, 8'h00);
    wrr(8'h48, 8'hA5);
    rdc(8'h48, 8'hA5);
    wrr(8'h49, 8'hFF);
    rdc(8'h49, 8'h7F);
    wrr(8'h49, 8'h00);
    wrr(8'h48, 8'h00);
    wrr(8'h41, 8'h02);
    wrr(8'h60, 8'h01);
    cyc(80);
    rdc(8'h43, 8'h00);
    wrr(8'h41, 8'h03);
    for (int c = 0; c < 5; c++) begin
      wrr(8'h60, 8'h00);
      wrr(8'h49, c < 4 ? 8'(c + 1) : 8'h21);
      wrr(8'h60, 8'h01);
      tmo(8'h02, c < 4 ? 1 << c : 16, 0, 1'b1);
      wrr(8'h49, 8'h00);
    end
    wrr(8'h60, 8'h00);
    sel <= 1'b1;
    for (int c = 1; c < 3; c++) begin
      wrr(8'h48, 8'(c));
      tmo(8'h04, (1 << (c - 1)) + 2, 0, 1'b0);
      wrr(8'h48, 8'h00);
    end
    {sel, conn, req_run} <= 3'h3;
    wrr(8'h48, 8'h30);
    cyc(60);
    rdc(8'h43, 8'h00);
    req_run <= 1'b0;
    tmo(8'h01, 4, 8, 1'b1);
    wrr(8'h48, 8'h00);
    {tmode, req_run} <= 2'h1;
    wrr(8'h48, 8'h30);
    tmo(8'h01, 4, 8, 1'b1);
    wrr(8'h48, 8'h00);
    {req_run, ack_run} <= 2'h1;
    wrr(8'h48, 8'h30);
    cyc(60);
    rdc(8'h43, 8'h00);
    wrr(8'h48, 8'h00);
    {ack_run, conn, bsy, req_run} <= 4'h3;
    wrr(8'h49, 8'h50);
    wrr(8'h48, 8'h10);
    cyc(100);
    rdc(8'h43, 8'h00);
    req_run <= 1'b0;
    tmo(8'h01, 16, 8, 1'b1);
    end_of_test();
  end
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end
endmodule : spt_top_tb
`default_nettype wire
